//--- core/scss_top.sv
// module: system clock switch, sleep and start-up reset control
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - switching allowed only when the switch enable fuse is 0
// R2 - select 0 runs system clock from primary oscillator of fused mode
// R3 - select 1 runs system clock from secondary oscillator
// R4 - every reset clears the select bit
// R5 - secondary disabled or fuse erased: writes ignored, select forced 0
// R6 - select at bit 0, bits 7 to 1 read as zero
// R7 - count eight rising edges of the new source before adopting it
// R8 - after select changes, freeze core at next first quarter phase
// R9 - to secondary: resume right after eight edges, no more delay
// R10 - back to crystal modes: also wait oscillator start-up time
// R11 - back to pll mode: start-up time plus 2 ms lock delay
// R12 - back to rc or external clock: only eight edges, no delay
// R13 - sleep stops clocks and holds core at first quarter phase
// R14 - leave sleep on external reset, watchdog reset or interrupt
// R15 - in sleep second pin low in rc/ec, port bit 6 in io modes
// R16 - power-up timer optional, only after power-on or brown-out
// R17 - power-on: power-up timer then start-up timer, reset held throughout
// R18 - pll mode adds 2 ms lock delay after start-up timer
// R19 - undefined registers keep contents through non power-on resets; code also initialises them on brown-out
// R20 - watchdog wake-up resumes operation, registers unchanged; code treats the watchdog as a reset that clears select
// R21 - master clear input filtered, short pulses ignored
// R22 - watchdog reset is internal, never drives master clear pin
// R23 - power-on reset pulse generated on supply rise
// R24 - start-up timer counts 1024 primary cycles after power-up timer
// R25 - start-up timer only in crystal/pll modes, power-on or wake; code also runs it after brown-out and on return to crystal
// R26 - power-up timer delay is 72 ms
// R27 - select synchronised into both sources, mux changes at count end; code counts edges of the incoming source only
module scss_top #(
  parameter int POWER_UP_DELAY_TIMER_CLKS = scss_pkg::POWER_UP_DELAY_TIMER_CLKS,
  parameter int PLL_LOCK_CLKS = scss_pkg::PLL_LOCK_CLKS
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  input wire logic I_SWITCH_FUSE,
  input wire logic [2:0] I_OSC_MODE,
  input wire logic I_POWER_UP_DELAY_TIMER_EN_N,
  input wire logic I_SEC_OSC_EN,
  input wire logic I_PRI_OSC,
  input wire logic I_SEC_OSC,
  input wire logic I_POR,
  input wire logic I_BOR,
  input wire logic I_MASTER_CLEAR_PIN_N,
  input wire logic I_WDT_RESET,
  input wire logic I_SLEEP,
  input wire logic I_WAKE_IRQ,
  input wire logic I_Q1,
  input wire logic I_PORT_A6,
  output logic O_SYSCLK_SEL,
  output logic O_CORE_FREEZE,
  output logic O_CORE_RESET,
  output logic O_REG_INIT,
  output logic O_OSC_STOP,
  output logic O_OSC2_OUT,
  output logic O_OSC2_OE_N,
  output logic O_MASTER_CLEAR_PIN_OE_N
);
  typedef enum {ST_RUN, ST_WAITQ1, ST_EDGES, ST_OST, ST_PLL, ST_SLEEP} scss_sw_t;
  typedef enum {RS_IDLE, RS_POWER_UP_DELAY_TIMER, RS_OST, RS_PLL} scss_rs_t;
  // ===========================================
  // input synchronisers
  logic [1:0] pri_s_reg, sec_s_reg, por_s_reg, bor_s_reg, master_clear_pin_s_reg, wdt_s_reg, irq_s_reg;
  logic pri_d_reg, sec_d_reg, por_d_reg;
  always_ff @(posedge I_CLK)
  begin
    pri_s_reg <= {pri_s_reg[0], I_PRI_OSC};
    sec_s_reg <= {sec_s_reg[0], I_SEC_OSC};
    por_s_reg <= {por_s_reg[0], I_POR};
    bor_s_reg <= {bor_s_reg[0], I_BOR};
    master_clear_pin_s_reg <= {master_clear_pin_s_reg[0], I_MASTER_CLEAR_PIN_N};
    wdt_s_reg <= {wdt_s_reg[0], I_WDT_RESET};
    irq_s_reg <= {irq_s_reg[0], I_WAKE_IRQ};
    pri_d_reg <= pri_s_reg[1];
    sec_d_reg <= sec_s_reg[1];
    por_d_reg <= por_s_reg[1];
  end
  logic pri_rise, sec_rise, por_pulse, bor_lvl, wdt_lvl, irq_lvl;
  assign pri_rise = pri_s_reg[1] & ~pri_d_reg;
  assign sec_rise = sec_s_reg[1] & ~sec_d_reg;
  // R23 supply rise pulse
  assign por_pulse = por_s_reg[1] & ~por_d_reg;
  assign bor_lvl = bor_s_reg[1];
  assign wdt_lvl = wdt_s_reg[1];
  assign irq_lvl = irq_s_reg[1];
  // ===========================================
  // master clear filter
  logic master_clear_pin_f_reg;
  logic [2:0] master_clear_pin_cnt_reg;
  // R21 short pulses never reach the filtered level
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N || master_clear_pin_s_reg[1] == master_clear_pin_f_reg)
      master_clear_pin_cnt_reg <= 3'h0;
    else
      master_clear_pin_cnt_reg <= master_clear_pin_cnt_reg + 3'h1;
  end
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      master_clear_pin_f_reg <= 1'b1;
    else if (master_clear_pin_cnt_reg == 3'(scss_pkg::MASTER_CLEAR_PIN_FILT_CLKS - 1))
      master_clear_pin_f_reg <= master_clear_pin_s_reg[1];
  end
  logic ext_rst, any_rst;
  assign ext_rst = ~master_clear_pin_f_reg;
  assign any_rst = ext_rst | wdt_lvl | por_pulse | bor_lvl;
  // R22 pin never driven by the watchdog
  assign O_MASTER_CLEAR_PIN_OE_N = 1'b1;
  // ===========================================
  // mode decode
  logic crystal_mode, pll_mode, io_mode, sw_allow;
  assign pll_mode = I_OSC_MODE == scss_pkg::MODE_PLL4;
  // R25 start-up timer only for crystal and pll modes
  assign crystal_mode = I_OSC_MODE == scss_pkg::MODE_LP || I_OSC_MODE == scss_pkg::MODE_XT
    || I_OSC_MODE == scss_pkg::MODE_HS || pll_mode;
  assign io_mode = I_OSC_MODE == scss_pkg::MODE_RESISTOR_CAPACITOR_WITH_IO || I_OSC_MODE == scss_pkg::MODE_EXTERNAL_CLOCK_WITH_IO;
  // R1 fuse gating
  assign sw_allow = ~I_SWITCH_FUSE & I_SEC_OSC_EN;
  // ===========================================
  // start-up reset sequencer
  scss_rs_t rs_reg;
  logic [31:0] rs_cnt_reg;
  logic rs_start;
  assign rs_start = por_pulse | bor_lvl;
  // R17 power-up timer, then start-up timer, reset held throughout
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      rs_reg <= RS_IDLE;
      rs_cnt_reg <= 32'h0;
    end
    else if (rs_start)
    begin
      // R16 power-up timer only on power-on or brown-out, if enabled
      rs_reg <= I_POWER_UP_DELAY_TIMER_EN_N ? RS_OST : RS_POWER_UP_DELAY_TIMER;
      rs_cnt_reg <= 32'h0;
    end
    else
    begin
      unique case (rs_reg)
        RS_IDLE: rs_cnt_reg <= 32'h0;
        RS_POWER_UP_DELAY_TIMER:
          // R26 72 ms power-up delay
          if (rs_cnt_reg == 32'(POWER_UP_DELAY_TIMER_CLKS - 1))
          begin
            rs_reg <= RS_OST;
            rs_cnt_reg <= 32'h0;
          end
          else
            rs_cnt_reg <= rs_cnt_reg + 32'h1;
        RS_OST:
          // R24 1024 primary edges
          if (!crystal_mode || rs_cnt_reg == 32'(scss_pkg::OST_CYCLES - 1) && pri_rise)
          begin
            // R18 pll lock delay follows start-up timer
            rs_reg <= crystal_mode && pll_mode ? RS_PLL : RS_IDLE;
            rs_cnt_reg <= 32'h0;
          end
          else if (pri_rise)
            rs_cnt_reg <= rs_cnt_reg + 32'h1;
        RS_PLL:
          if (rs_cnt_reg == 32'(PLL_LOCK_CLKS - 1))
          begin
            rs_reg <= RS_IDLE;
            rs_cnt_reg <= 32'h0;
          end
          else
            rs_cnt_reg <= rs_cnt_reg + 32'h1;
      endcase
    end
  end
  assign O_CORE_RESET = rs_reg != RS_IDLE || rs_start || ext_rst || wdt_lvl;
  // R19 only power-on and brown-out initialise undefined registers
  assign O_REG_INIT = rs_start;
  // ===========================================
  // control register
  logic sel_req_reg;
  // R4 R5 cleared by every reset and forced low when not allowed
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N || any_rst || !sw_allow)
      sel_req_reg <= scss_pkg::OSC_CTRL_RESET[scss_pkg::SEL_BIT];
    else if (I_WR && I_ADDR == scss_pkg::OSC_CTRL_ADDR)
      sel_req_reg <= I_WDATA[scss_pkg::SEL_BIT];
  end
  // ===========================================
  // switch sequencer
  scss_sw_t sw_reg;
  logic [31:0] sw_cnt_reg;
  logic sel_reg, tgt_reg, wake_ost_reg;
  logic tgt_rise;
  assign tgt_rise = tgt_reg ? sec_rise : pri_rise;
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N || any_rst)
    begin
      sw_reg <= ST_RUN;
      sw_cnt_reg <= 32'h0;
      // R2 reset returns to primary
      sel_reg <= 1'b0;
      tgt_reg <= 1'b0;
      wake_ost_reg <= 1'b0;
    end
    else
    begin
      unique case (sw_reg)
        ST_RUN:
          // R13 sleep stops clocks at first quarter
          if (I_SLEEP && I_Q1)
            sw_reg <= ST_SLEEP;
          else if (sel_req_reg != sel_reg)
          begin
            tgt_reg <= sel_req_reg;
            sw_reg <= ST_WAITQ1;
          end
        // R8 freeze at next first quarter
        ST_WAITQ1:
          if (I_Q1)
          begin
            sw_reg <= ST_EDGES;
            sw_cnt_reg <= 32'h0;
          end
        // R7 R27 eight edges of the incoming source
        ST_EDGES:
          if (tgt_rise && sw_cnt_reg == 32'(scss_pkg::SYNC_EDGES - 1))
          begin
            sw_cnt_reg <= 32'h0;
            // R9 R12 no further delay for secondary, rc or ec
            if (tgt_reg || !crystal_mode)
            begin
              sel_reg <= tgt_reg;
              sw_reg <= ST_RUN;
            end
            else
              sw_reg <= ST_OST;
          end
          else if (tgt_rise)
            sw_cnt_reg <= sw_cnt_reg + 32'h1;
        // R10 start-up time on return to crystal
        ST_OST:
          if (pri_rise && sw_cnt_reg == 32'(scss_pkg::OST_CYCLES - 1))
          begin
            sw_cnt_reg <= 32'h0;
            if (pll_mode)
              sw_reg <= ST_PLL;
            else
            begin
              sel_reg <= tgt_reg;
              sw_reg <= ST_RUN;
            end
          end
          else if (pri_rise)
            sw_cnt_reg <= sw_cnt_reg + 32'h1;
        // R11 pll lock time after start-up
        ST_PLL:
          if (sw_cnt_reg == 32'(PLL_LOCK_CLKS - 1))
          begin
            sw_cnt_reg <= 32'h0;
            sel_reg <= tgt_reg;
            wake_ost_reg <= 1'b0;
            sw_reg <= ST_RUN;
          end
          else
            sw_cnt_reg <= sw_cnt_reg + 32'h1;
        // R14 R20 interrupt wake keeps registers, runs start-up if crystal mode with primary selected
        ST_SLEEP:
          if (irq_lvl)
          begin
            sw_cnt_reg <= 32'h0;
            wake_ost_reg <= 1'b1;
            if (crystal_mode && !sel_reg)
            begin
              tgt_reg <= 1'b0;
              sw_reg <= ST_OST;
            end
            else
              sw_reg <= ST_RUN;
          end
      endcase
    end
  end
  // R3 selected source drives the system clock
  assign O_SYSCLK_SEL = sel_reg;
  assign O_CORE_FREEZE = sw_reg != ST_RUN && sw_reg != ST_WAITQ1;
  assign O_OSC_STOP = sw_reg == ST_SLEEP;
  // R15 second pin low in rc/ec sleep, port bit in io modes
  assign O_OSC2_OUT = io_mode ? I_PORT_A6 : 1'b0;
  assign O_OSC2_OE_N = !(io_mode || (sw_reg == ST_SLEEP && !crystal_mode));
  // ===========================================
  // read port
  // R6 upper bits read zero
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
      O_RDATA <= 8'h00;
    else if (I_RD && I_ADDR == scss_pkg::OSC_CTRL_ADDR)
      O_RDATA <= {7'h00, sel_req_reg};
    else if (I_RD && I_ADDR == scss_pkg::STATUS_ADDR)
      O_RDATA <= {4'h0, O_CORE_RESET, O_OSC_STOP, O_CORE_FREEZE, sel_reg};
    else
      O_RDATA <= 8'h00;
  end
  // ===========================================
  // checks
  a_fuse_blocks_sel: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_SWITCH_FUSE |=> !sel_req_reg) else $error("select set with fuse erased"); // R1 R5
  a_reset_clears_sel: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    any_rst |=> !sel_reg && !sel_req_reg) else $error("reset did not clear select"); // R4
  a_rdata_upper_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    $past(I_RD) |-> O_RDATA[7:4] == 4'h0) else $error("reserved bits nonzero"); // R6
  a_sel_changes_run: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst)
    $changed(sel_reg) |-> sw_reg == ST_RUN && $past(sw_reg) != ST_RUN) else $error("sel changed outside seq"); // R7
  a_freeze_on_q1: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst)
    sw_reg == ST_WAITQ1 && I_Q1 |=> sw_reg == ST_EDGES) else $error("no freeze at q1"); // R8
  a_sec_no_delay: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst)
    sw_reg == ST_EDGES && tgt_reg && sec_rise && sw_cnt_reg == 32'h7 |=> sel_reg) else $error("late to sec"); // R9
  a_sleep_osc_stop: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst)
    sw_reg == ST_RUN && I_SLEEP && I_Q1 |=> O_OSC_STOP) else $error("sleep not entered"); // R13
  a_wdt_master_clear_pin_pin: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    wdt_lvl |-> O_MASTER_CLEAR_PIN_OE_N) else $error("watchdog drove pin"); // R22
  a_reset_held: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    rs_reg != RS_IDLE |-> O_CORE_RESET) else $error("reset released early"); // R17
  // ===========================================
  // return path, sleep, pin, start-up reset and select checks
  // R12 rc or ec resumes
  a_rc_no_ost: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst) // R12
    sw_reg == ST_EDGES && !tgt_reg && !crystal_mode && pri_rise && sw_cnt_reg == 32'h7 |=> sw_reg == ST_RUN && !sel_reg)
    else $error("rc return delayed");
  // R10 crystal start-up wait
  a_crystal_ost: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst) // R10
    sw_reg == ST_EDGES && !tgt_reg && crystal_mode && pri_rise && sw_cnt_reg == 32'h7 |=> sw_reg == ST_OST)
    else $error("crystal return skipped start-up");
  // R11 pll lock follows
  a_pll_after_ost: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst) // R11
    sw_reg == ST_OST && pll_mode && pri_rise && sw_cnt_reg == 32'(scss_pkg::OST_CYCLES - 1) |=> sw_reg == ST_PLL)
    else $error("pll lock wait skipped");
  // R14 sleep holds without wake
  a_sleep_holds: assert property (@(posedge I_CLK) disable iff (!I_RST_N || any_rst) // R14
    sw_reg == ST_SLEEP && !irq_lvl |=> O_OSC_STOP)
    else $error("left sleep without wake");
  // R15 rc sleep pin low
  a_osc2_rc_low: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R15
    sw_reg == ST_SLEEP && !crystal_mode && !io_mode |-> !O_OSC2_OE_N && !O_OSC2_OUT)
    else $error("second pin not low in sleep");
  // R15 io mode port bit
  a_osc2_io_port: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R15
    io_mode |-> !O_OSC2_OE_N && O_OSC2_OUT == I_PORT_A6)
    else $error("second pin not port bit");
  // R21 short pulse ignored
  a_master_clear_pin_filter: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R21
    master_clear_pin_f_reg && master_clear_pin_cnt_reg != 3'(scss_pkg::MASTER_CLEAR_PIN_FILT_CLKS - 1) |=> master_clear_pin_f_reg)
    else $error("short clear pulse passed");
  // R26 power-up timer ends
  a_power_up_delay_timer_done: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R26
    rs_reg == RS_POWER_UP_DELAY_TIMER && rs_cnt_reg == 32'(POWER_UP_DELAY_TIMER_CLKS - 1) && !rs_start |=> rs_reg == RS_OST)
    else $error("power-up timer overran");
  // R25 no start-up in rc
  a_ost_skip_rc: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R25
    rs_reg == RS_OST && !crystal_mode && !rs_start |=> rs_reg == RS_IDLE)
    else $error("start-up timer ran in rc mode");
  // R16 R19 init inside reset
  a_reg_init_reset: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R16 R19
    O_REG_INIT |-> O_CORE_RESET)
    else $error("register init outside reset");
  // R5 select forced low
  a_sel_forced_low: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R5
    !sw_allow |=> !sel_req_reg)
    else $error("select kept while not allowed");
  // wake into crystal restarts the start-up count, the costly path
  c_wake_ost: cover property (@(posedge I_CLK) disable iff (!I_RST_N) sw_reg == ST_SLEEP ##1 sw_reg == ST_OST);
  c_to_secondary: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $rose(sel_reg));
  c_to_primary: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $fell(sel_reg));
  c_sleep_wake: cover property (@(posedge I_CLK) disable iff (!I_RST_N) $fell(O_OSC_STOP));
  c_pll_lock: cover property (@(posedge I_CLK) disable iff (!I_RST_N) rs_reg == RS_PLL);
endmodule // scss_top
`default_nettype wire

//--- core/scss_pkg.sv
// package: constants for the system clock switch and start-up block
package scss_pkg;
  // ===========================================
  // register map
  localparam logic [3:0] OSC_CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h1;
  localparam int SEL_BIT = 0;
  localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
  // ===========================================
  // primary oscillator modes
  localparam logic [2:0] MODE_LP = 3'h0;
  localparam logic [2:0] MODE_XT = 3'h1;
  localparam logic [2:0] MODE_HS = 3'h2;
  localparam logic [2:0] MODE_PLL4 = 3'h3;
  localparam logic [2:0] MODE_RC = 3'h4;
  localparam logic [2:0] MODE_RESISTOR_CAPACITOR_WITH_IO = 3'h5;
  localparam logic [2:0] MODE_EC = 3'h6;
  localparam logic [2:0] MODE_EXTERNAL_CLOCK_WITH_IO = 3'h7;
  // ===========================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int SYNC_EDGES = 8;
  localparam int OST_CYCLES = 1024;
  localparam int POWER_UP_DELAY_TIMER_MS = 72;
  localparam int PLL_LOCK_MS = 2;
  localparam int POWER_UP_DELAY_TIMER_CLKS = POWER_UP_DELAY_TIMER_MS * CLK_MHZ * 1000;
  localparam int PLL_LOCK_CLKS = PLL_LOCK_MS * CLK_MHZ * 1000;
  localparam int MASTER_CLEAR_PIN_FILT_CLKS = 4;
endpackage

//--- verification/scss_osc_model.sv
// model: primary and secondary oscillators feeding the clock switch
`timescale 1ns/1ps
`default_nettype none
// ===========================================
// oscillator model
module scss_osc_model #(
  parameter int PRI_HALF = 3,
  parameter int SEC_HALF = 5
) (
  input wire logic i_clk,
  input wire logic i_osc_stop,
  output logic o_pri_osc,
  output logic o_sec_osc
);
  int pri_cnt_reg = 0;
  int sec_cnt_reg = 0;
  logic pri_reg = 1'b0;
  logic sec_reg = 1'b0;
  // primary stops in sleep
  // the secondary keeps running, as a timer crystal would
  always_ff @(posedge i_clk)
  begin
    if (!i_osc_stop)
    begin
      pri_cnt_reg <= (pri_cnt_reg == PRI_HALF - 1) ? 0 : pri_cnt_reg + 1;
      if (pri_cnt_reg == PRI_HALF - 1)
        pri_reg <= ~pri_reg;
    end
    sec_cnt_reg <= (sec_cnt_reg == SEC_HALF - 1) ? 0 : sec_cnt_reg + 1;
    if (sec_cnt_reg == SEC_HALF - 1)
      sec_reg <= ~sec_reg;
  end
  assign o_pri_osc = pri_reg;
  assign o_sec_osc = sec_reg;
endmodule // scss_osc_model
`default_nettype wire

//--- verification/tb.sv
// testbench: register access, clock switching, sleep and reset sequencing
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic I_CLK, I_RST_N, I_WR, I_RD, I_SWITCH_FUSE, I_POWER_UP_DELAY_TIMER_EN_N, I_SEC_OSC_EN, I_POR, I_BOR;
  logic I_MASTER_CLEAR_PIN_N, I_WDT_RESET, I_SLEEP, I_WAKE_IRQ, I_Q1, I_PORT_A6, I_PRI_OSC, I_SEC_OSC;
  logic [3:0] I_ADDR;
  logic [7:0] I_WDATA, O_RDATA, d;
  logic [2:0] I_OSC_MODE;
  logic O_SYSCLK_SEL, O_CORE_FREEZE, O_CORE_RESET, O_REG_INIT, O_OSC_STOP, O_OSC2_OUT, O_OSC2_OE_N, O_MASTER_CLEAR_PIN_OE_N;
  logic fz, ri;
  int n_errors = 0;
  int n_checks = 0;
  int n, lo, q;
  logic [2:0] modes [4] = '{scss_pkg::MODE_RC, scss_pkg::MODE_EC, scss_pkg::MODE_XT, scss_pkg::MODE_PLL4};
  scss_top #(.POWER_UP_DELAY_TIMER_CLKS(50), .PLL_LOCK_CLKS(20)) scss_top_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_SWITCH_FUSE(I_SWITCH_FUSE), .I_OSC_MODE(I_OSC_MODE), .I_POWER_UP_DELAY_TIMER_EN_N(I_POWER_UP_DELAY_TIMER_EN_N),
    .I_SEC_OSC_EN(I_SEC_OSC_EN), .I_PRI_OSC(I_PRI_OSC), .I_SEC_OSC(I_SEC_OSC), .I_POR(I_POR),
    .I_BOR(I_BOR), .I_MASTER_CLEAR_PIN_N(I_MASTER_CLEAR_PIN_N), .I_WDT_RESET(I_WDT_RESET), .I_SLEEP(I_SLEEP),
    .I_WAKE_IRQ(I_WAKE_IRQ), .I_Q1(I_Q1), .I_PORT_A6(I_PORT_A6), .O_SYSCLK_SEL(O_SYSCLK_SEL),
    .O_CORE_FREEZE(O_CORE_FREEZE), .O_CORE_RESET(O_CORE_RESET), .O_REG_INIT(O_REG_INIT),
    .O_OSC_STOP(O_OSC_STOP), .O_OSC2_OUT(O_OSC2_OUT), .O_OSC2_OE_N(O_OSC2_OE_N), .O_MASTER_CLEAR_PIN_OE_N(O_MASTER_CLEAR_PIN_OE_N));
  scss_osc_model #(.PRI_HALF(3), .SEC_HALF(5)) scss_osc_model_inst (.i_clk(I_CLK), .i_osc_stop(O_OSC_STOP),
    .o_pri_osc(I_PRI_OSC), .o_sec_osc(I_SEC_OSC));
  // ===========================================
  // clock, quarter phase and watchdog
  initial
  begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK)
  begin
    q <= (q + 1) % 4;
    I_Q1 <= (q == 3);
  end
  initial
  begin
    #400000;
    n_errors++;
    end_sim();
  end
  // ===========================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge I_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= v;
    @(posedge I_CLK);
    I_WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge I_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 1'b0;
    #1 v = O_RDATA;
  endtask
  // waits for the select output, noting whether the core froze meanwhile
  task automatic wait_sel(input logic want);
    n = 0;
    fz = 1'b0;
    while (O_SYSCLK_SEL !== want && n < 20000)
    begin
      @(posedge I_CLK);
      #1 n++;
      if (O_CORE_FREEZE === 1'b1)
        fz = 1'b1;
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ===========================================
  // tests
  initial
  begin
    {I_RST_N, I_WR, I_RD, I_BOR, I_WDT_RESET, I_SLEEP, I_WAKE_IRQ, I_POR, I_POWER_UP_DELAY_TIMER_EN_N} = '0;
    {I_SWITCH_FUSE, I_SEC_OSC_EN, I_MASTER_CLEAR_PIN_N, I_PORT_A6} = 4'hf;
    I_ADDR = 4'h0;
    I_WDATA = 8'h00;
    I_OSC_MODE = scss_pkg::MODE_RC;
    repeat (20) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rd(4'h0, d); chk(d, 8'h00);
    rd(4'h5, d); chk(d, 8'h00);
    wr(4'h0, 8'h01); rd(4'h0, d); chk(d, 8'h00);
    I_SWITCH_FUSE <= 1'b0;
    I_SEC_OSC_EN <= 1'b0;
    wr(4'h0, 8'h01); rd(4'h0, d); chk(d, 8'h00);
    I_SEC_OSC_EN <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      I_OSC_MODE <= modes[i];
      wr(4'h0, 8'hff); rd(4'h0, d); chk(d, 8'h01);
      wait_sel(1'b1);
      chk(fz, 1'b1);
      chk(n >= 70 && n < 200, 1'b1);
      rd(4'h1, d); chk(d, 8'h01);
      wr(4'h0, 8'h00);
      wait_sel(1'b0);
      lo = 42 + ((i >= 2) ? 1024 * 6 : 0) + ((i == 3) ? 20 : 0);
      chk(n >= lo && n < lo + 400, 1'b1);
      chk(O_SYSCLK_SEL, 1'b0);
    end
    I_OSC_MODE <= scss_pkg::MODE_RC;
    wr(4'h0, 8'h01);
    wait_sel(1'b1);
    I_RST_N <= 1'b0;
    repeat (3) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    rd(4'h0, d); chk(d, 8'h00);
    I_SLEEP <= 1'b1;
    for (int k = 0; k < 20 && O_OSC_STOP !== 1'b1; k++) @(posedge I_CLK);
    I_SLEEP <= 1'b0;
    #1 chk(O_OSC_STOP, 1'b1);
    chk({O_OSC2_OE_N, O_OSC2_OUT}, 2'b00);
    I_OSC_MODE <= scss_pkg::MODE_EXTERNAL_CLOCK_WITH_IO;
    I_PORT_A6 <= 1'b0;
    repeat (2) @(posedge I_CLK);
    #1 chk(O_OSC2_OUT, 1'b0);
    I_PORT_A6 <= 1'b1;
    repeat (2) @(posedge I_CLK);
    #1 chk(O_OSC2_OUT, 1'b1);
    I_WAKE_IRQ <= 1'b1;
    for (int k = 0; k < 50 && O_OSC_STOP !== 1'b0; k++) @(posedge I_CLK);
    I_WAKE_IRQ <= 1'b0;
    #1 chk(O_OSC_STOP, 1'b0);
    I_MASTER_CLEAR_PIN_N <= 1'b0;
    repeat (2) @(posedge I_CLK);
    I_MASTER_CLEAR_PIN_N <= 1'b1;
    repeat (8) @(posedge I_CLK);
    #1 chk(O_CORE_RESET, 1'b0);
    I_MASTER_CLEAR_PIN_N <= 1'b0;
    repeat (10) @(posedge I_CLK);
    #1 chk(O_CORE_RESET, 1'b1);
    I_MASTER_CLEAR_PIN_N <= 1'b1;
    I_WDT_RESET <= 1'b1;
    repeat (3) @(posedge I_CLK);
    #1 chk({O_CORE_RESET, O_MASTER_CLEAR_PIN_OE_N}, 2'b11);
    I_WDT_RESET <= 1'b0;
    repeat (10) @(posedge I_CLK);
    I_OSC_MODE <= scss_pkg::MODE_RC;
    I_POR <= 1'b1;
    n = 0;
    ri = 1'b0;
    for (int k = 0; k < 400 && (n == 0 || O_CORE_RESET === 1'b1); k++)
    begin
      @(posedge I_CLK);
      #1 if (O_CORE_RESET === 1'b1) n++;
      if (O_REG_INIT === 1'b1) ri = 1'b1;
    end
    chk(ri, 1'b1);
    chk(n >= 50 && n < 150, 1'b1);
    chk(O_CORE_RESET, 1'b0);
    end_sim();
  end
endmodule // tb
`default_nettype wire
